//--- dci_ctrl.v
/*
  DDR3 command-port controller: AXI4-Lite register slave, link clock,
  bank tracking, refresh timer, command pins and a simple data burst.
  Assumes a DDR3 device on the pins and a bench that resolves the
  two-way strobe and data pins from the output enables.
*/
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "dci_defs.vh"
// Notes on behaviour
// - Controller drives clock pair; device samples where true rises.
// - Clock-gate high runs the device, low halts it.
// - Clock-gate low with all banks idle enters power-down.
// - Bank number goes with activate, read, write, single precharge.
// - Activate carries the full fourteen-bit row address.
// - Read or write carries the ten-bit column address.
// - Mode register set carries the op-code on the address bus.
// - 8192 refreshes per 64 ms, every 7.8 us, up to 85 degrees.
// - Above 85 degrees refresh doubles to every 3.9 us.
// - Data moves with the strobe; controller drives it on writes.
// - Chip-select high masks commands; low is part of the code.
// - Row strobe low, column high: activate or precharge by write-select.
// - Row strobe high, column low: read or write by write-select.
// - Address bit ten: auto precharge, or all banks on precharge.
module dci_ctrl #(
  parameter HALF = 4,
  parameter GAP = 4
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire diff_clk_true,
  output wire diff_clk_comp,
  output reg cke,
  output reg cs_n,
  output reg ras_n,
  output reg cas_n,
  output reg we_n,
  output reg [2:0] bnk_select,
  output reg [13:0] addr_bus,
  input wire dqs_in,
  output reg dqs_out,
  output reg dqs_oe,
  input wire [7:0] dq_in,
  output reg [7:0] dq_out,
  output reg dq_oe
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SLOT = 3'h1;
  localparam [2:0] ST_GAP = 3'h2;
  localparam [2:0] ST_LAT = 3'h3;
  localparam [2:0] ST_BURST = 3'h4;
  localparam [31:0] NORM_W = `DCI_TREFI_NORM_NS / `DCI_CLK_NS;
  localparam [31:0] HOT_W = `DCI_TREFI_HOT_NS / `DCI_CLK_NS;
  localparam [31:0] GAP_W = GAP - 1;
  localparam [9:0] NORM_CYC = NORM_W[9:0];
  localparam [9:0] HOT_CYC = HOT_W[9:0];
  localparam [3:0] GAP_LAST = GAP_W[3:0];

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function [2:0] reg_idx;
    input [7:0] a;
    begin
      case (a)
        `DCI_OFF_CTRL: reg_idx = `DCI_IDX_CTRL;
        `DCI_OFF_ADDR: reg_idx = `DCI_IDX_ADDR;
        `DCI_OFF_CFG: reg_idx = `DCI_IDX_CFG;
        `DCI_OFF_WDATA: reg_idx = `DCI_IDX_WDATA;
        `DCI_OFF_RDATA: reg_idx = `DCI_IDX_RDATA;
        `DCI_OFF_STAT: reg_idx = `DCI_IDX_STAT;
        default: reg_idx = `DCI_IDX_NONE;
      endcase
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------
  // Link clock and bank table
  // ----------------------------------------
  wire rise_p;
  wire fall_p;
  wire mid_p;
  dci_clkgen #(.HALF(HALF)) u_clk (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_true(diff_clk_true),
    .clk_comp(diff_clk_comp),
    .rise_p(rise_p),
    .fall_p(fall_p),
    .mid_p(mid_p)
  );

  reg [31:0] addr_reg;
  reg [31:0] cfg;
  reg [31:0] wdata_reg;
  reg [31:0] rdata_reg;
  reg [7:0] open_mask;
  reg [3:0] job;
  reg [2:0] st;
  reg [3:0] gap_cnt;
  reg fin;
  reg is_rd;
  reg [4:0] lat_cnt;
  reg [3:0] beat;
  reg err;
  reg ref_due;
  reg [9:0] ref_cnt;
  reg [3:0] next_cmd;
  reg [13:0] next_addr;
  reg next_all;
  reg next_fin;
  reg next_data;
  wire [13:0] row_q;
  wire [2:0] a_bank = addr_reg[`DCI_ADDR_BANK];
  wire [13:0] a_row = addr_reg[`DCI_ADDR_ROW];
  wire issue = (st == ST_SLOT) && fall_p;
  wire tbl_we = issue && (next_cmd == `DCI_PIN_ACT);

  dci_bank_table #(.DEPTH(8), .AW(3), .DW(14)) u_tbl (
    .aclk(aclk),
    .we(tbl_we),
    .waddr(a_bank),
    .wdata(a_row),
    .raddr(a_bank),
    .rdata(row_q)
  );

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_wr = aw_held && w_held && !s_axi_bvalid;
  wire [2:0] wr_idx = reg_idx(aw_addr);
  wire [2:0] rd_idx = reg_idx(s_axi_araddr);
  wire [31:0] stat = {16'h0000, open_mask, 4'h0, ref_due, err, cke, st != ST_IDLE};

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DCI_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DCI_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      addr_reg <= 32'h00000000;
      cfg <= `DCI_CFG_RST;
      wdata_reg <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_idx == `DCI_IDX_NONE) ? `DCI_RESP_SLVERR : `DCI_RESP_OKAY;
        if (wr_idx == `DCI_IDX_ADDR) begin
          addr_reg <= merge(addr_reg, w_data, w_strb);
        end
        if (wr_idx == `DCI_IDX_CFG) begin
          cfg <= merge(cfg, w_data, w_strb);
        end
        if (wr_idx == `DCI_IDX_WDATA) begin
          wdata_reg <= merge(wdata_reg, w_data, w_strb);
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= (rd_idx == `DCI_IDX_NONE) ? `DCI_RESP_SLVERR : `DCI_RESP_OKAY;
        case (rd_idx)
          `DCI_IDX_CTRL: s_axi_rdata <= {28'h0000000, job};
          `DCI_IDX_ADDR: s_axi_rdata <= addr_reg;
          `DCI_IDX_CFG: s_axi_rdata <= cfg;
          `DCI_IDX_WDATA: s_axi_rdata <= wdata_reg;
          `DCI_IDX_RDATA: s_axi_rdata <= rdata_reg;
          `DCI_IDX_STAT: s_axi_rdata <= stat;
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Latency, refresh and strobe sampling
  // ----------------------------------------
  wire [4:0] cl = {1'b0, cfg[`DCI_CFG_CL]};
  reg [4:0] al;
  always @* begin
    case (cfg[`DCI_CFG_AL])
      `DCI_AL_CLM1: al = cl - 5'h01;
      `DCI_AL_CLM2: al = cl - 5'h02;
      default: al = 5'h00;
    endcase
  end
  wire [4:0] lat_tgt = is_rd ? (al + cl) : (al + {1'b0, cfg[`DCI_CFG_CWL]});
  wire [3:0] bl = cfg[`DCI_CFG_BL8] ? 4'h8 : 4'h4;

  reg [8:0] sync1;
  reg [8:0] sync2;
  reg [8:0] sync3;
  reg dqs_acc;
  // Read data are edge aligned, so the byte seen once the strobe has settled is the one launched by that edge
  wire dqs_edge = (sync2[8] == sync3[8]) && (sync3[8] != dqs_acc);

  wire idle = (st == ST_IDLE);
  wire ctrl_wr = do_wr && (wr_idx == `DCI_IDX_CTRL) && w_strb[0];
  wire [3:0] req = w_data[`DCI_CTRL_JOB];
  // While halted only a wake is accepted, since the device is frozen
  wire req_ok = cke ? (req >= `DCI_JOB_RD && req <= `DCI_JOB_PD) : (req == `DCI_JOB_WAKE);
  wire sw_go = ctrl_wr && idle && req_ok;
  wire ref_go = idle && !ctrl_wr && ref_due && cke;
  wire tmo = (st == ST_BURST) && is_rd && rise_p && (lat_cnt == `DCI_RD_TMO);
  wire err_clr = do_wr && (wr_idx == `DCI_IDX_STAT) && w_strb[0] && w_data[`DCI_ST_ERR];
  wire ref_hit = (ref_cnt == 10'h000) && cfg[`DCI_CFG_REFEN];

  // ----------------------------------------
  // Next pin command
  // ----------------------------------------
  always @* begin
    next_cmd = `DCI_PIN_DES;
    next_addr = 14'h0000;
    next_all = 1'b0;
    next_fin = 1'b1;
    next_data = 1'b0;
    case (job)
      `DCI_JOB_RD, `DCI_JOB_WR: begin
        next_fin = 1'b0;
        if (!open_mask[a_bank]) begin
          next_cmd = `DCI_PIN_ACT;
          next_addr = a_row;
        end else if (row_q != a_row) begin
          next_cmd = `DCI_PIN_PRE;
        end else begin
          next_cmd = (job == `DCI_JOB_RD) ? `DCI_PIN_RD : `DCI_PIN_WR;
          next_addr[9:0] = addr_reg[`DCI_ADDR_COL];
          next_addr[`DCI_AP_BIT] = addr_reg[`DCI_ADDR_AP];
          next_addr[`DCI_BC_BIT] = 1'b1;
          next_data = 1'b1;
        end
      end
      `DCI_JOB_PRE: begin
        next_cmd = `DCI_PIN_PRE;
      end
      `DCI_JOB_PREALL, `DCI_JOB_REF, `DCI_JOB_MRS, `DCI_JOB_PD: begin
        // Refresh, mode set and power-down all need every bank idle first
        if (|open_mask) begin
          next_cmd = `DCI_PIN_PRE;
          next_all = 1'b1;
          next_addr[`DCI_AP_BIT] = 1'b1;
          next_fin = (job == `DCI_JOB_PREALL);
        end else if (job == `DCI_JOB_REF) begin
          next_cmd = `DCI_PIN_REF;
        end else if (job == `DCI_JOB_MRS) begin
          next_cmd = `DCI_PIN_MRS;
          next_addr = a_row;
        end
      end
      default: begin
        next_fin = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // Sequencer and pins
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      st <= ST_IDLE;
      job <= `DCI_JOB_NONE;
      gap_cnt <= 4'h0;
      fin <= 1'b0;
      is_rd <= 1'b0;
      lat_cnt <= 5'h00;
      beat <= 4'h0;
      err <= 1'b0;
      ref_due <= 1'b0;
      ref_cnt <= NORM_CYC - 10'h001;
      open_mask <= 8'h00;
      rdata_reg <= 32'h00000000;
      sync1 <= 9'h000;
      sync2 <= 9'h000;
      sync3 <= 9'h000;
      dqs_acc <= 1'b0;
      cke <= 1'b0;
      {cs_n, ras_n, cas_n, we_n} <= `DCI_PIN_DES;
      bnk_select <= 3'h0;
      addr_bus <= 14'h0000;
      dqs_out <= 1'b0;
      dqs_oe <= 1'b0;
      dq_out <= 8'h00;
      dq_oe <= 1'b0;
    end else begin
      sync1 <= {dqs_in, dq_in};
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2[8] == sync3[8]) begin
        dqs_acc <= sync3[8];
      end
      err <= (ctrl_wr && !sw_go) | tmo | (err & ~err_clr);
      ref_cnt <= (ref_cnt == 10'h000) ? ((cfg[`DCI_CFG_HOT] ? HOT_CYC : NORM_CYC) - 10'h001)
                                      : ref_cnt - 10'h001;
      ref_due <= ref_hit | (ref_due & ~ref_go);
      if (fall_p) begin
        {cs_n, ras_n, cas_n, we_n} <= `DCI_PIN_DES;
      end
      case (st)
        ST_IDLE: begin
          if (sw_go) begin
            job <= req;
            st <= ST_SLOT;
          end else if (ref_go) begin
            job <= `DCI_JOB_REF;
            st <= ST_SLOT;
          end
        end
        ST_SLOT: begin
          if (fall_p) begin
            {cs_n, ras_n, cas_n, we_n} <= next_cmd;
            bnk_select <= a_bank;
            addr_bus <= next_addr;
            if (next_cmd == `DCI_PIN_ACT) begin
              open_mask[a_bank] <= 1'b1;
            end
            if (next_all) begin
              open_mask <= 8'h00;
            end else if (next_cmd == `DCI_PIN_PRE || (next_data && addr_reg[`DCI_ADDR_AP])) begin
              open_mask[a_bank] <= 1'b0;
            end
            if (job == `DCI_JOB_PD && next_fin) begin
              cke <= 1'b0;
            end
            if (job == `DCI_JOB_WAKE) begin
              cke <= 1'b1;
            end
            is_rd <= (job == `DCI_JOB_RD);
            lat_cnt <= 5'h00;
            gap_cnt <= 4'h0;
            fin <= next_fin;
            st <= next_data ? ST_LAT : ST_GAP;
          end
        end
        ST_GAP: begin
          if (fall_p) begin
            gap_cnt <= gap_cnt + 4'h1;
            if (gap_cnt == GAP_LAST) begin
              st <= fin ? ST_IDLE : ST_SLOT;
              if (fin) begin
                job <= `DCI_JOB_NONE;
              end
            end
          end
        end
        ST_LAT: begin
          if (rise_p) begin
            lat_cnt <= lat_cnt + 5'h01;
            if (lat_cnt == lat_tgt) begin
              st <= ST_BURST;
              beat <= 4'h0;
              lat_cnt <= 5'h00;
              if (!is_rd) begin
                dqs_oe <= 1'b1;
                dq_oe <= 1'b1;
                dqs_out <= 1'b0;
                dq_out <= wdata_reg[7:0];
              end
            end
          end
        end
        ST_BURST: begin
          if (is_rd) begin
            if (rise_p) begin
              lat_cnt <= lat_cnt + 5'h01;
            end
            if (dqs_edge) begin
              rdata_reg <= {sync3[7:0], rdata_reg[31:8]};
              beat <= beat + 4'h1;
            end
            if ((dqs_edge && beat == bl - 4'h1) || tmo) begin
              st <= ST_GAP;
              fin <= 1'b1;
            end
          end else begin
            // Strobe toggles mid-way through each byte so the device samples a settled value
            if (mid_p && beat != bl) begin
              dqs_out <= ~dqs_out;
              beat <= beat + 4'h1;
            end
            if (rise_p || fall_p) begin
              if (beat == bl) begin
                dqs_oe <= 1'b0;
                dq_oe <= 1'b0;
                st <= ST_GAP;
                fin <= 1'b1;
              end else begin
                dq_out <= wdata_reg[{beat[1:0], 3'b000} +: 8];
              end
            end
          end
        end
        default: begin
          st <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- dci_defs.vh
/*
  Shared constants of the DDR3 command-port controller: register map,
  field layouts, reset values, job codes, pin command codes, timing.
  Assumes it is included by the controller and the bench and nowhere else.
*/
`ifndef DCI_DEFS_VH
`define DCI_DEFS_VH
// ----------------------------------------
// Register byte offsets and indexes
// ----------------------------------------
`define DCI_OFF_CTRL 8'h00
`define DCI_OFF_ADDR 8'h04
`define DCI_OFF_CFG 8'h08
`define DCI_OFF_WDATA 8'h0C
`define DCI_OFF_RDATA 8'h10
`define DCI_OFF_STAT 8'h14
`define DCI_IDX_CTRL 3'h0
`define DCI_IDX_ADDR 3'h1
`define DCI_IDX_CFG 3'h2
`define DCI_IDX_WDATA 3'h3
`define DCI_IDX_RDATA 3'h4
`define DCI_IDX_STAT 3'h5
`define DCI_IDX_NONE 3'h7
// ----------------------------------------
// Fields
// ----------------------------------------
`define DCI_CTRL_JOB 3:0
`define DCI_ADDR_ROW 13:0
`define DCI_ADDR_COL 25:16
`define DCI_ADDR_BANK 30:28
`define DCI_ADDR_AP 31
`define DCI_CFG_CL 3:0
`define DCI_CFG_CWL 7:4
`define DCI_CFG_AL 9:8
`define DCI_CFG_BL8 10
`define DCI_CFG_ILV 11
`define DCI_CFG_HOT 12
`define DCI_CFG_REFEN 13
`define DCI_CFG_RST 32'h00002469
`define DCI_ST_BUSY 0
`define DCI_ST_CKE 1
`define DCI_ST_ERR 2
`define DCI_ST_REF 3
`define DCI_ST_OPEN 15:8
`define DCI_AP_BIT 10
`define DCI_BC_BIT 12
// ----------------------------------------
// Jobs and pin commands {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------
`define DCI_JOB_NONE 4'h0
`define DCI_JOB_RD 4'h1
`define DCI_JOB_WR 4'h2
`define DCI_JOB_PRE 4'h3
`define DCI_JOB_PREALL 4'h4
`define DCI_JOB_REF 4'h5
`define DCI_JOB_MRS 4'h6
`define DCI_JOB_PD 4'h7
`define DCI_JOB_WAKE 4'h8
`define DCI_PIN_DES 4'hF
`define DCI_PIN_ACT 4'h3
`define DCI_PIN_PRE 4'h2
`define DCI_PIN_RD 4'h5
`define DCI_PIN_WR 4'h4
`define DCI_PIN_REF 4'h1
`define DCI_PIN_MRS 4'h0
`define DCI_AL_ZERO 2'h0
`define DCI_AL_CLM1 2'h1
`define DCI_AL_CLM2 2'h2
// ----------------------------------------
// Timing and bus answers
// ----------------------------------------
`define DCI_CLK_NS 25
`define DCI_TREFI_NORM_NS 7800
`define DCI_TREFI_HOT_NS 3900
`define DCI_RD_TMO 5'h10
`define DCI_RESP_OKAY 2'h0
`define DCI_RESP_SLVERR 2'h2
`endif

//--- dci_clkgen.v
/*
  Link clock divider: makes the differential clock pair and one-cycle
  pulses at its rising edge, falling edge and each half-period middle.
  Assumes a single system clock with synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dci_clkgen #(
  parameter HALF = 4
) (
  input wire aclk,
  input wire aresetn,
  output reg clk_true,
  output reg clk_comp,
  output reg rise_p,
  output reg fall_p,
  output reg mid_p
);
  localparam [31:0] LAST_W = HALF - 1;
  localparam [31:0] MID_W = HALF / 2 - 1;
  localparam [7:0] LAST = LAST_W[7:0];
  localparam [7:0] MID = MID_W[7:0];
  reg [7:0] cnt;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 8'h00;
      clk_true <= 1'b0;
      clk_comp <= 1'b1;
      rise_p <= 1'b0;
      fall_p <= 1'b0;
      mid_p <= 1'b0;
    end else begin
      rise_p <= 1'b0;
      fall_p <= 1'b0;
      mid_p <= 1'b0;
      if (cnt == LAST) begin
        cnt <= 8'h00;
        clk_true <= ~clk_true;
        clk_comp <= ~clk_comp;
        rise_p <= ~clk_true;
        fall_p <= clk_true;
      end else begin
        cnt <= cnt + 8'h01;
        if (cnt == MID) begin
          mid_p <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- dci_bank_table.v
/*
  Open-row table: one row address per bank, registered read port.
  Assumes the caller keeps its own valid bits; contents start unknown.
*/
`timescale 1ns/1ps
`default_nettype none
module dci_bank_table #(
  parameter DEPTH = 8,
  parameter AW = 3,
  parameter DW = 14
) (
  input wire aclk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:DEPTH-1];

  always @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

//--- dci_checker.sv
/*
  Pin checker for the DDR3 command-port controller.
  Assumes it is bound to dci_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module dci_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic diff_clk_true,
  input wire logic diff_clk_comp,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] bnk_select,
  input wire logic [13:0] addr_bus,
  input wire logic dqs_oe,
  input wire logic dq_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic ck_q;
  logic [7:0] opn;
  wire rise = diff_clk_true & ~ck_q;
  wire cmd = rise & cke & ~cs_n;
  // Open banks as the device sees them, so idle-only commands can be judged
  always_ff @(posedge aclk) begin
    ck_q <= diff_clk_true;
    if (!aresetn)
      opn <= 8'h00;
    else if (cmd && !ras_n && cas_n)
      opn <= we_n ? opn | (8'h01 << bnk_select) : addr_bus[10] ? 8'h00 : opn & ~(8'h01 << bnk_select);
    else if (cmd && ras_n && !cas_n && addr_bus[10])
      opn <= opn & ~(8'h01 << bnk_select);
  end
  clk_pair_a: assert property (diff_clk_comp == !diff_clk_true)
    else $error("clock pair not complementary");
  cmd_hold_a: assert property (rise |-> $stable({cs_n, ras_n, cas_n, we_n, bnk_select, addr_bus}))
    else $error("command pins moved at sampling edge");
  cmd_len_a: assert property (cmd |-> ##[1:16] cs_n)
    else $error("command held too long");
  gate_off_a: assert property (!cke |-> cs_n)
    else $error("command while clock gated");
  pd_idle_a: assert property ($fell(cke) |-> opn == 8'h00)
    else $error("power-down with open bank");
  act_closed_a: assert property (cmd && !ras_n && cas_n && we_n |-> !opn[bnk_select])
    else $error("activate on open bank");
  ref_idle_a: assert property (cmd && !ras_n && !cas_n && we_n |-> opn == 8'h00)
    else $error("refresh with open bank");
  strobe_pair_a: assert property (dq_oe == dqs_oe)
    else $error("data driven without strobe");
endmodule
bind dci_ctrl dci_checker dci_checker_i (.aclk, .aresetn, .diff_clk_true, .diff_clk_comp, .cke, .cs_n,
  .ras_n, .cas_n, .we_n, .bnk_select, .addr_bus, .dqs_oe, .dq_oe);
`default_nettype wire

//--- dci_dev.sv
/*
  Behavioural DDR3 device: decodes commands, keeps rows and mode words,
  answers reads edge-aligned, captures write bytes.
  Assumes the bench resolves the shared strobe and data lines.
*/
`timescale 1ns/1ps
`default_nettype none
module dci_dev #(
  parameter LAT = 9
) (
  input wire logic diff_clk_true,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] bnk_select,
  input wire logic [13:0] addr_bus,
  input wire logic dqs_out,
  input wire logic dqs_oe,
  input wire logic [7:0] dq_out,
  output var logic dqs_m,
  output var logic [7:0] dq_m,
  output var logic oe_m
);
  logic [13:0] row [8];
  logic [13:0] mr [8];
  logic [9:0] col;
  logic [2:0] bank;
  logic [63:0] wq;
  logic [7:0] b;
  int nref = 0;
  int i;
  initial begin
    oe_m = 1'b0;
    dqs_m = 1'b0;
    dq_m = 8'h00;
  end
  always @(posedge diff_clk_true) begin
    if (cke && !cs_n) begin
      case ({ras_n, cas_n, we_n})
        3'b011: row[bnk_select] <= addr_bus;
        3'b101, 3'b100: begin
          col <= addr_bus[9:0];
          bank <= bnk_select;
        end
        3'b001: nref <= nref + 1;
        3'b000: mr[bnk_select] <= addr_bus;
        default: ;
      endcase
    end
  end
  // Blocking read burst: a second read during a burst would be missed
  always @(posedge diff_clk_true) begin
    if (cke && !cs_n && {ras_n, cas_n, we_n} == 3'b101) begin
      b = addr_bus[7:0];
      repeat (LAT - 1) @(posedge diff_clk_true);
      oe_m = 1'b1;
      dqs_m = 1'b0;
      @(posedge diff_clk_true);
      for (i = 0; i < 8; i++) begin
        dq_m = b + i[7:0];
        dqs_m = ~dqs_m;
        @(diff_clk_true);
      end
      oe_m = 1'b0;
    end
  end
  always @(dqs_out) if (dqs_oe) wq = {dq_out, wq[63:8]};
endmodule
`default_nettype wire

//--- tb_top.sv
/*
  Self-checking bench for dci_ctrl with the device model.
  Assumes AXI4-Lite register access and a 40 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dci_defs.vh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_mismatch++; $display("Error %s expected %h seen %h", n, e, s); end end
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire diff_clk_true, diff_clk_comp, cke, cs_n, ras_n, cas_n, we_n, dqs_out, dqs_oe, dq_oe, dqs_m, oe_m;
  wire [2:0] bnk_select;
  wire [13:0] addr_bus;
  wire [7:0] dq_out, dq_m;
  // Undriven lines show the inverse of the last value, never a stale copy
  wire dqs_in = dqs_oe ? dqs_out : oe_m ? dqs_m : ~dqs_m;
  wire [7:0] dq_in = dq_oe ? dq_out : oe_m ? dq_m : ~dq_m;
  int n_mismatch = 0, compares = 0;
  logic [31:0] rv;
  always #12.5 aclk = ~aclk;
  dci_ctrl #(.HALF(4), .GAP(1)) dci_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .diff_clk_true, .diff_clk_comp, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bnk_select, .addr_bus,
    .dqs_in, .dqs_out, .dqs_oe, .dq_in, .dq_out, .dq_oe);
  dci_dev #(.LAT(9)) dci_dev_i (.diff_clk_true, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bnk_select, .addr_bus,
    .dqs_out, .dqs_oe, .dq_out, .dqs_m, .dq_m, .oe_m);
  function automatic logic [31:0] adr(input logic [2:0] bk, input logic [9:0] c, input logic [13:0] r);
    return {1'b0, bk, 2'h0, c, 2'h0, r};
  endfunction
  task automatic wrap_up;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic hang(input int k);
    if (k >= 400) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 400; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    hang(k);
    s_axi_bready <= 1'b0;
    `CHK("bresp", r, s_axi_bresp)
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 400; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    hang(k);
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    `CHK("rresp", r, s_axi_rresp)
  endtask
  task automatic job(input logic [3:0] j, input logic [31:0] a);
    int k;
    wr(`DCI_OFF_ADDR, a, 2'h0);
    wr(`DCI_OFF_CTRL, {28'h0, j}, 2'h0);
    for (k = 0; k < 400; k++) begin
      rd(`DCI_OFF_STAT, 2'h0);
      if (rv[0] === 1'b0) break;
    end
    hang(k);
    `CHK("err", 1'b0, rv[2])
  endtask
  task automatic t_reset;
    `CHK("pins", 4'hF, {cs_n, ras_n, cas_n, we_n})
    rd(`DCI_OFF_CFG, 2'h0);
    `CHK("cfg", `DCI_CFG_RST, rv)
    // Refresh off, so it cannot collide with a job order
    wr(`DCI_OFF_CFG, `DCI_CFG_RST & ~32'h00002000, 2'h0);
    rd(8'h1C, `DCI_RESP_SLVERR);
    wr(8'h1C, 32'h0, `DCI_RESP_SLVERR);
    `CHK("cke", 1'b0, cke)
  endtask
  task automatic t_mode;
    job(`DCI_JOB_WAKE, 32'h0);
    `CHK("cke", 1'b1, cke)
    job(`DCI_JOB_MRS, adr(3'h2, 10'h0, 14'h1234));
    `CHK("mode", 14'h1234, dci_dev_i.mr[2])
  endtask
  task automatic t_write;
    wr(`DCI_OFF_WDATA, 32'hA1B2C3D4, 2'h0);
    job(`DCI_JOB_WR, adr(3'h5, 10'h2A8, 14'h3ABC));
    `CHK("row", 14'h3ABC, dci_dev_i.row[5])
    `CHK("bank", 3'h5, dci_dev_i.bank)
    `CHK("col", 10'h2A8, dci_dev_i.col)
    `CHK("wdata", 64'hA1B2C3D4A1B2C3D4, dci_dev_i.wq)
  endtask
  task automatic t_read;
    job(`DCI_JOB_RD, adr(3'h5, 10'h010, 14'h3ABC));
    rd(`DCI_OFF_RDATA, 2'h0);
    `CHK("rdata", 32'h17161514, rv)
    job(`DCI_JOB_RD, adr(3'h5, 10'h000, 14'h0155));
    `CHK("reopen", 14'h0155, dci_dev_i.row[5])
  endtask
  task automatic t_refresh;
    int n;
    wr(`DCI_OFF_CFG, `DCI_CFG_RST, 2'h0);
    n = dci_dev_i.nref;
    repeat (3120) @(posedge aclk);
    `CHK("ref_norm", 1'b1, dci_dev_i.nref - n inside {[9:11]})
    wr(`DCI_OFF_CFG, `DCI_CFG_RST | 32'h00001000, 2'h0);
    repeat (312) @(posedge aclk);
    n = dci_dev_i.nref;
    repeat (3120) @(posedge aclk);
    `CHK("ref_hot", 1'b1, dci_dev_i.nref - n inside {[19:21]})
    wr(`DCI_OFF_CFG, `DCI_CFG_RST & ~32'h00002000, 2'h0);
    repeat (100) @(posedge aclk);
    job(`DCI_JOB_PD, 32'h0);
    `CHK("cke", 1'b0, cke)
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_mode();
    t_write();
    t_read();
    t_refresh();
    wrap_up();
  end
endmodule
`default_nettype wire
